// [rtl/sscr_regs.sv]
// Behaviour
// [R01] Read-only fault flag register at 0x56, zero after reset.
// [R02] Bit 7 shows a conversion error in the latest acquisition.
// [R03] Bit 6 shows supply suspected too low for pressure accuracy.
// [R04] Bits 5 and 4 show pressure overflow and underflow.
// [R05] Bits 3 and 2 show temperature overflow and underflow.
// [R06] Bits 1 and 0 show voltage overflow and underflow.
// [R07] Set flags clear only at frame end when acknowledge is requested; the code also replaces all flags with each new acquisition result.
// [R08] Command register at 0x57 resets to zero; writing zero does nothing.
// [R09] Acknowledge bit clears main status and fault flags at frame end; the code clears the fault flags and with them only main status bit 0.
// [R10] Device clears each command bit once its action is done.
// [R11] Flush bit empties the pressure queue at frame end.
// [R12] Register reset bit restores read/write registers at frame end.
// [R13] Firmware check bit starts one verification at frame end.
// [R14] Cell self-test bit starts one pressure-cell test at frame end.
// [R15] Converter self-test bit starts one converter test at frame end.
// [R16] Host leaves command bits 6 and 5 alone.
// [R17] Main status bit 0 is high exactly when any fault flag is set.
// [R18] Frame end is chip-select release; pending actions happen then.
module sscr_regs
  import sscr_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  input  wire logic         spi_sclk_i,
  input  wire logic         spi_cs_n_i,
  input  wire logic         spi_mosi_i,
  output logic              spi_miso_o,
  output logic              spi_miso_oe_o,
  input  wire logic         acq_done_i,
  input  wire sscr_faults_s acq_faults_i,
  input  wire logic [7:1]   main_status_i,
  output logic              acquisition_error_summary_o,
  output sscr_act_s         actions_o,
  output logic [7:0]        command_requests_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_pipe <= SSCR_RST_SYNC;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  default clocking chk_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Pin synchronisers and agreement filter
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_filt;
  logic [2:0] pin_prev;

  assign pin_raw = {spi_sclk_i, spi_cs_n_i, spi_mosi_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      logic [2:0] sync;
      always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          // Chip select idles high: no false frame after reset
          sync         <= (gi == 1) ? ~SSCR_PIN_RST : SSCR_PIN_RST;
          pin_filt[gi] <= (gi == 1);
          pin_prev[gi] <= (gi == 1);
        end else begin
          sync <= {sync[1:0], pin_raw[gi]};
          if (sync[1] == sync[2]) begin
            pin_filt[gi] <= sync[2];
          end
          pin_prev[gi] <= pin_filt[gi];
        end
      end
    end
  endgenerate

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic cs_start;
  logic seq_end;
  logic mosi_bit;

  assign sclk_rise = pin_filt[2] & ~pin_prev[2];
  assign sclk_fall = ~pin_filt[2] & pin_prev[2];
  assign cs_active = ~pin_filt[1];
  assign cs_start  = ~pin_filt[1] & pin_prev[1];
  assign seq_end   = pin_filt[1] & ~pin_prev[1];
  assign mosi_bit  = pin_filt[0];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  sscr_state_e  state;
  sscr_state_e  next_state;
  logic [4:0]   bit_cnt;
  logic [4:0]   next_bit_cnt;
  logic [7:0]   rx_sh;
  logic [7:0]   next_rx_sh;
  logic [7:0]   tx_sh;
  logic [7:0]   next_tx_sh;
  logic         miso;
  logic         next_miso;
  sscr_hdr_s    hdr;
  sscr_hdr_s    next_hdr;
  sscr_faults_s flags;
  sscr_faults_s next_flags;
  logic [7:0]   cmd;
  logic [7:0]   next_cmd;
  sscr_act_s    act;
  sscr_act_s    next_act;
  logic         summary;

  assign summary = |flags; // [R17]

  function automatic logic [7:0] read_mux(input logic [6:0] addr,
                                          input logic [7:0] flt,
                                          input logic [7:0] cm,
                                          input logic [7:1] ms,
                                          input logic       sm);
    case (addr)
      SSCR_ADDR_MAIN:  read_mux = {ms, sm};
      SSCR_ADDR_FLAGS: read_mux = flt;
      SSCR_ADDR_CMD:   read_mux = cm & SSCR_CMD_WMASK;
      default:         read_mux = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_rx_sh   = rx_sh;
    next_tx_sh   = tx_sh;
    next_miso    = miso;
    next_hdr     = hdr;
    next_flags   = flags;
    next_cmd     = cmd;
    next_act     = '0;

    case (state)
      SSCR_ST_IDLE: begin
        if (cs_start) begin
          next_state   = SSCR_ST_ADDR;
          next_bit_cnt = SSCR_CNT_RST;
          next_miso    = 1'b0;
        end
      end
      SSCR_ST_ADDR: begin
        if (sclk_rise) begin
          next_rx_sh   = {rx_sh[6:0], mosi_bit};
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == SSCR_HDR_LAST) begin
            next_hdr   = {rx_sh[6:0], mosi_bit};
            next_tx_sh = read_mux(next_hdr.addr, flags, cmd,
                                  main_status_i, summary);
            next_state = SSCR_ST_DATA;
          end
        end
      end
      SSCR_ST_DATA: begin
        if (sclk_fall) begin
          next_miso  = tx_sh[7];
          next_tx_sh = {tx_sh[6:0], 1'b0};
        end
        if (sclk_rise) begin
          next_rx_sh   = {rx_sh[6:0], mosi_bit};
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt == SSCR_DATA_LAST) begin
            next_state = SSCR_ST_HOLD;
            if (hdr.wr && hdr.addr == SSCR_ADDR_CMD) begin
              // Only ones are taken; reserved bits stay zero
              next_cmd = cmd | ({rx_sh[6:0], mosi_bit}
                                & SSCR_CMD_WMASK); // [R08] [R16]
            end
          end
        end
      end
      SSCR_ST_HOLD: begin
        if (sclk_fall) begin
          next_miso = 1'b0;
        end
      end
      default: begin
        next_state = SSCR_ST_IDLE;
      end
    endcase

    if (!cs_active) begin
      next_state = SSCR_ST_IDLE;
    end

    // Actions run once at chip-select release
    if (seq_end) begin // [R18]
      next_act.acknowledge_flags_request    = cmd[SSCR_CMD_ACK];    // [R09]
      next_act.flush_pressure_queue_request = cmd[SSCR_CMD_FLUSH];  // [R11]
      next_act.register_reset_request       = cmd[SSCR_CMD_REGRST]; // [R12]
      next_act.firmware_check_request       = cmd[SSCR_CMD_FWCHK];  // [R13]
      next_act.cell_selftest_request        = cmd[SSCR_CMD_CELLST]; // [R14]
      next_act.converter_selftest_request   = cmd[SSCR_CMD_CONVST]; // [R15]
      next_cmd = SSCR_CMD_RST; // [R10]
      if (cmd[SSCR_CMD_ACK]) begin
        next_flags = SSCR_FLAGS_RST; // [R07] [R09]
      end
    end

    // New acquisition wins over an acknowledge in the same cycle
    if (acq_done_i) begin
      next_flags = acq_faults_i; // [R02] [R03] [R04] [R05] [R06]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state   <= SSCR_ST_IDLE;
      bit_cnt <= SSCR_CNT_RST;
      rx_sh   <= 8'h00;
      tx_sh   <= 8'h00;
      miso    <= 1'b0;
      hdr     <= '0;
      flags   <= SSCR_FLAGS_RST; // [R01]
      cmd     <= SSCR_CMD_RST;   // [R08]
      act     <= '0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      rx_sh   <= next_rx_sh;
      tx_sh   <= next_tx_sh;
      miso    <= next_miso;
      hdr     <= next_hdr;
      flags   <= next_flags;
      cmd     <= next_cmd;
      act     <= next_act;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign spi_miso_o                  = miso;
  assign spi_miso_oe_o               = cs_active;
  assign acquisition_error_summary_o = summary;
  assign actions_o                   = act;
  assign command_requests_o          = cmd;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_ack_end;
    seq_end && cmd[SSCR_CMD_ACK] && !acq_done_i;
  endsequence

  sequence seq_cmd_write;
    sclk_rise && state == SSCR_ST_DATA && bit_cnt == SSCR_DATA_LAST
      && hdr.wr && hdr.addr == SSCR_ADDR_CMD && cs_active;
  endsequence

  chk_flags_latest: assert property ( // [R02]
    acq_done_i |=> flags == $past(acq_faults_i))
    else $error("fault flags did not take the acquisition result");

  chk_ack_clears: assert property ( // [R07]
    seq_ack_end |=> flags == SSCR_FLAGS_RST ##0
      act.acknowledge_flags_request)
    else $error("acknowledge did not clear the fault flags");

  chk_flags_hold: assert property ( // [R07]
    !acq_done_i && !(seq_end && cmd[SSCR_CMD_ACK]) |=> $stable(flags))
    else $error("fault flags changed without cause");

  chk_cmd_write: assert property ( // [R08]
    seq_cmd_write |=> (cmd & ~$past(cmd)) ==
      ($past({rx_sh[6:0], mosi_bit}) & SSCR_CMD_WMASK & ~$past(cmd)))
    else $error("command write not taken as ones only");

  chk_cmd_reserved: assert property ( // [R16]
    cmd[6:5] == 2'h0)
    else $error("reserved command bits became set");

  chk_cmd_once: assert property ( // [R10]
    seq_end |=> cmd == SSCR_CMD_RST ##1 act == '0)
    else $error("command not cleared or action repeated");

  chk_flush_act: assert property ( // [R11]
    seq_end |=> act.flush_pressure_queue_request == $past(cmd[SSCR_CMD_FLUSH]))
    else $error("flush request not issued at frame end");

  chk_regrst_act: assert property ( // [R12]
    seq_end && cmd[SSCR_CMD_REGRST] |=> act.register_reset_request)
    else $error("register reset not issued at frame end");

  chk_tests_act: assert property ( // [R13]
    seq_end |=> {act.firmware_check_request, act.cell_selftest_request,
                 act.converter_selftest_request} == $past(cmd[2:0]))
    else $error("test requests not issued at frame end");

  chk_act_only_end: assert property ( // [R18]
    act != '0 |-> $past(seq_end))
    else $error("action issued outside frame end");

  chk_summary_bit: assert property ( // [R17]
    acq_done_i && acq_faults_i != '0 |=> acquisition_error_summary_o)
    else $error("summary bit missing after faulty acquisition");

endmodule

// [common/sscr_pkg.sv]
package sscr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SSCR_ADDR_MAIN  = 7'h55;
  localparam logic [6:0] SSCR_ADDR_FLAGS = 7'h56;
  localparam logic [6:0] SSCR_ADDR_CMD   = 7'h57;

  localparam logic [7:0] SSCR_FLAGS_RST  = 8'h00;
  localparam logic [7:0] SSCR_CMD_RST    = 8'h00;
  // Bits 6 and 5 of the command register are not writable
  localparam logic [7:0] SSCR_CMD_WMASK  = 8'h9F;

  // ----------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------
  localparam int SSCR_CMD_ACK    = 7;
  localparam int SSCR_CMD_FLUSH  = 4;
  localparam int SSCR_CMD_REGRST = 3;
  localparam int SSCR_CMD_FWCHK  = 2;
  localparam int SSCR_CMD_CELLST = 1;
  localparam int SSCR_CMD_CONVST = 0;

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam logic [4:0] SSCR_HDR_LAST  = 5'h07;
  localparam logic [4:0] SSCR_DATA_LAST = 5'h0F;
  localparam logic [4:0] SSCR_CNT_RST   = 5'h00;
  localparam logic [1:0] SSCR_RST_SYNC  = 2'h0;
  localparam logic [2:0] SSCR_PIN_RST   = 3'h0;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
  } sscr_hdr_s;

  // Bit order matches the fault flag register
  typedef struct packed {
    logic conversion_error_flag;
    logic low_supply_warning;
    logic pressure_overflow_flag;
    logic pressure_underflow_flag;
    logic temperature_overflow_flag;
    logic temperature_underflow_flag;
    logic voltage_overflow_flag;
    logic voltage_underflow_flag;
  } sscr_faults_s;

  typedef struct packed {
    logic acknowledge_flags_request;
    logic flush_pressure_queue_request;
    logic register_reset_request;
    logic firmware_check_request;
    logic cell_selftest_request;
    logic converter_selftest_request;
  } sscr_act_s;

  typedef enum logic [3:0] {
    SSCR_ST_IDLE = 4'b0001,
    SSCR_ST_ADDR = 4'b0010,
    SSCR_ST_DATA = 4'b0100,
    SSCR_ST_HOLD = 4'b1000
  } sscr_state_e;

endpackage

// [sim/sscr_host_model.sv]
module sscr_host_model
  import sscr_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic spi_miso_i,
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // ----------------------------------------------------------------
  // One frame: header then data, MSB first, mode 0, 800 ns sclk
  // ----------------------------------------------------------------
  task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
    logic [15:0] word;
    word = tx;
    if (tx[15:8] == {1'b1, SSCR_ADDR_CMD}) begin
      word[6:5] = 2'b00;
    end
    rx = 8'h00;
    @(posedge core_clk_i);
    spi_cs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi_o <= word[i];
      wait_clk(4);
      spi_sclk_o <= 1'b1;
      wait_clk(4);
      if (i < 8) begin
        rx = {rx[6:0], spi_miso_i};
      end
      spi_sclk_o <= 1'b0;
    end
    wait_clk(4);
    spi_cs_n_o <= 1'b1;
    spi_mosi_o <= ~word[0];
    wait_clk(12);
  endtask
endmodule

// [sim/tb_sscr_regs.sv]
module tb_sscr_regs
  import sscr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic         core_clk_i;
  logic         resetn_i;
  logic         spi_sclk;
  logic         spi_cs_n;
  logic         spi_mosi;
  logic         spi_miso;
  logic         spi_miso_oe;
  logic         miso_line;
  logic         acq_done;
  sscr_faults_s acq_faults;
  logic [7:1]   main_status;
  logic         summary;
  sscr_act_s    actions;
  logic [7:0]   cmd_req;
  logic [5:0]   act_seen;
  int           act_cnt;
  int           err_total;
  int           check_count;

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  sscr_regs u_sscr_regs (
    .core_clk_i                  (core_clk_i),
    .resetn_i                    (resetn_i),
    .spi_sclk_i                  (spi_sclk),
    .spi_cs_n_i                  (spi_cs_n),
    .spi_mosi_i                  (spi_mosi),
    .spi_miso_o                  (spi_miso),
    .spi_miso_oe_o               (spi_miso_oe),
    .acq_done_i                  (acq_done),
    .acq_faults_i                (acq_faults),
    .main_status_i               (main_status),
    .acquisition_error_summary_o (summary),
    .actions_o                   (actions),
    .command_requests_o          (cmd_req)
  );

  sscr_host_model u_sscr_host_model (
    .core_clk_i (core_clk_i),
    .spi_miso_i (miso_line),
    .spi_sclk_o (spi_sclk),
    .spi_cs_n_o (spi_cs_n),
    .spi_mosi_o (spi_mosi)
  );

  // Released line shows the inverse of the last driven bit
  assign miso_line = spi_miso_oe ? spi_miso : ~spi_miso;

  // Collects action pulses away from the active edge
  always @(negedge core_clk_i) begin
    if (actions !== 6'h00) begin
      act_seen = act_seen | actions;
      act_cnt++;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    u_sscr_host_model.frame({1'b0, a, 8'h00}, d);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    act_seen = 6'h00;
    act_cnt  = 0;
    u_sscr_host_model.frame({1'b1, a, d}, unused);
  endtask

  task automatic acq(input logic [7:0] f);
    @(posedge core_clk_i);
    acq_done   <= 1'b1;
    acq_faults <= f;
    @(posedge core_clk_i);
    acq_done   <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    rd(SSCR_ADDR_FLAGS, d);
    chk(d, SSCR_FLAGS_RST);
    rd(SSCR_ADDR_CMD, d);
    chk(d, SSCR_CMD_RST);
    chk({7'h00, summary}, 8'h00);
    chk({7'h00, spi_miso_oe}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_faults();
    logic [7:0] d;
    for (int b = 0; b < 8; b++) begin
      acq(8'h01 << b);
      rd(SSCR_ADDR_FLAGS, d);
      chk(d, 8'h01 << b);
      chk({7'h00, summary}, 8'h01);
      rd(SSCR_ADDR_MAIN, d);
      chk(d, {main_status, 1'b1});
    end
    wr(SSCR_ADDR_FLAGS, 8'h00);
    rd(SSCR_ADDR_FLAGS, d);
    chk(d, 8'h80);
    rd(7'h10, d);
    chk(d, 8'h00);
    $display("test faults done");
  endtask

  task automatic t_cmds();
    logic [7:0] d;
    logic [7:0] c;
    int         bits [6] = '{7, 4, 3, 2, 1, 0};
    foreach (bits[k]) begin
      c = 8'h01 << bits[k];
      acq(8'h81);
      wr(SSCR_ADDR_CMD, c);
      chk({2'h0, act_seen}, {2'h0, c[7], c[4:0]});
      chk(8'(act_cnt), 8'h01);
      chk(cmd_req, 8'h00);
      rd(SSCR_ADDR_FLAGS, d);
      chk(d, c[7] ? 8'h00 : 8'h81);
      chk({7'h00, summary}, {7'h00, ~c[7]});
    end
    $display("test commands done");
  endtask

  task automatic t_zero_all();
    wr(SSCR_ADDR_CMD, 8'h00);
    chk({2'b00, act_seen}, 8'h00);
    chk(8'(act_cnt), 8'h00);
    wr(SSCR_ADDR_CMD, 8'h9F);
    chk({2'b00, act_seen}, 8'h3F);
    chk(8'(act_cnt), 8'h01);
    chk(cmd_req, 8'h00);
    $display("test zero and all done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #5000000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    resetn_i    = 1'b0;
    acq_done    = 1'b0;
    acq_faults  = 8'h00;
    main_status = 7'h5A;
    err_total   = 0;
    check_count = 0;
    act_seen    = 6'h00;
    act_cnt     = 0;
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    t_reset();
    t_faults();
    t_cmds();
    t_zero_all();
    tally_and_finish();
  end
endmodule
